//--- rtl/ctdp_pkg.sv
package ctdp_pkg;
    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int DW = 16;
    localparam int AW = 10;
    localparam int LW = 16;
    localparam int PW = 12;
    localparam int BW = 5;
    localparam int N_USER = 8;
    localparam int N_DED = 7;
    localparam int FIFO_DEPTH = 16;
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int MAX_RATE_HZ = 2_000_000;
    // Shortest pattern period in ticks, rounded up
    localparam int MIN_PERIOD = (SYS_CLK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
    localparam int BYTE_BEATS = DW / 8;
    localparam logic [DW-1:0] MSB_BIT = {1'b1, {(DW-1){1'b0}}};
    // Dedicated pattern channel positions
    localparam int D_STIM = 0;
    localparam int D_CAPT = 1;
    localparam int D_BYTE = 2;
    localparam int D_SER = 3;
    localparam int D_LOAD = 4;
    localparam int D_STORE = 5;
    localparam int D_WIN = 6;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {XF_PAR = 2'h0, XF_BYTE = 2'h1, XF_SER = 2'h2} ctdp_xfer_t;
    typedef enum logic [1:0] {CS_INT = 2'h0, CS_FRONT = 2'h1, CS_BP = 2'h2} ctdp_csel_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_SETTLE = 3'h1, ST_MEAS = 3'h3, ST_DRAIN = 3'h2, ST_DONE = 3'h6
    } ctdp_st_t;
    typedef struct packed {
        logic src;
        ctdp_xfer_t xfer;
        logic msb_inv;
        logic [DW-1:0] mask;
        logic [LW-1:0] settle;
        logic [LW-1:0] meas;
        logic [AW-1:0] base;
        logic [AW-1:0] len;
        logic [PW-1:0] period;
        logic [PW-1:0] capt_phase;
        ctdp_csel_t csel;
    } ctdp_cfg_t;
    typedef struct packed {
        logic wr;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } ctdp_host_t;
    typedef struct packed {
        ctdp_st_t st;
        logic front_q;
        logic bp_q;
        logic [PW-1:0] phase;
        logic [BW-1:0] beat;
        logic keep;
        logic [AW-1:0] sample;
        logic [LW-1:0] loop;
        logic [AW-1:0] cap_addr;
        logic fetch_act;
        logic [AW-1:0] fetch_idx;
        logic [LW:0] fetch_loop;
        logic rd_pend;
        logic [DW-1:0] shreg;
        logic ready;
        logic underrun;
        logic overrun;
        logic [N_USER-1:0] user;
        logic [N_DED-1:0] ded;
        logic [DW-1:0] dout;
        logic doe;
        logic sout;
    } ctdp_state_t;
endpackage

//--- rtl/ctdp_top.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Word FIFO
// ----------------------------------------------------------------
module ctdp_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [W-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [W-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int A = $clog2(DEPTH);
    typedef struct packed {
        logic [A-1:0] wp;
        logic [A-1:0] rp;
        logic [A:0] cnt;
    } ctdp_fptr_t;
    ctdp_fptr_t s, next_s;
    logic [W-1:0] mem [DEPTH];
    logic push, pop;

    // Handshakes; depth must be a power of two for the pointer wrap
    assign in_ready_out = s.cnt != (A+1)'(DEPTH);
    assign out_valid_out = s.cnt != '0;
    assign out_data_out = mem[s.rp];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wp = s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = s.rp + 1'b1;
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
        if (push) begin
            mem[s.wp] <= in_data_in;
        end
    end
endmodule

// ----------------------------------------------------------------
// Pattern window compare
// ----------------------------------------------------------------
module ctdp_chan #(
    parameter int P = 12
) (
    // Phase and window
    input wire logic [P-1:0] phase_in,
    input wire logic [P-1:0] on_in,
    input wire logic [P-1:0] off_in,
    // Result
    output logic hit_out
);
    assign hit_out = (phase_in >= on_in) && (phase_in < off_in);
endmodule

// ----------------------------------------------------------------
// Timing and data path
// ----------------------------------------------------------------
module ctdp_top import ctdp_pkg::*; #(
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Configuration and control
    input wire ctdp_cfg_t cfg_in,
    input wire logic [N_USER-1:0][PW-1:0] user_on_in,
    input wire logic [N_USER-1:0][PW-1:0] user_off_in,
    input wire logic start_in,
    input wire logic config_in,
    // Pattern clock sources
    input wire logic front_clk_in,
    input wire logic bp_clk_in,
    // Host memory port
    input wire ctdp_host_t host_in,
    output logic [DW-1:0] rd_data_out,
    // Converter side
    input wire logic [DW-1:0] dut_data_in,
    input wire logic dut_serial_in,
    output logic [DW-1:0] dut_data_out,
    output logic dut_data_oe_out,
    output logic dut_serial_out,
    // Pattern outputs and status
    output logic [N_USER-1:0] user_out,
    output logic [N_DED-1:0] ded_out,
    output logic ready_out,
    output logic underrun_out,
    output logic overrun_out
);
    ctdp_state_t s, next_s;
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] mem_q;
    logic [N_USER-1:0] hit;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [DW-1:0] f_in_data, f_out_data;
    logic tick, running, last_phase, stim_evt, capt_evt, start_ok, drained;
    logic stall, pace;
    logic cap_we, mem_we;
    logic [AW-1:0] raddr, waddr;
    logic [DW-1:0] wdata;
    logic [PW-1:0] period;

    function automatic logic [BW-1:0] beats_of(input ctdp_xfer_t x);
        case (x)
            XF_PAR: beats_of = BW'(1);
            XF_BYTE: beats_of = BW'(BYTE_BEATS);
            XF_SER: beats_of = BW'(DW);
            default: beats_of = BW'(1);
        endcase
    endfunction

    // User channel windows
    for (genvar i = 0; i < N_USER; i++) begin : g_user
        ctdp_chan #(.P(PW)) u_chan (
            .phase_in(s.phase),
            .on_in(user_on_in[i]),
            .off_in(user_off_in[i]),
            .hit_out(hit[i])
        );
    end

    // Capture words in, stimulus words out; a full FIFO stalls the stimulus fetch
    ctdp_fifo #(.W(DW), .DEPTH(FIFO_DEPTH_P)) u_fifo (
        .clk_in(sys_clk_in),
        .rst_in(rst_in),
        .in_valid_in(f_in_valid),
        .in_data_in(f_in_data),
        .in_ready_out(f_in_ready),
        .out_valid_out(f_out_valid),
        .out_data_out(f_out_data),
        .out_ready_in(f_out_ready)
    );

    // ------------------------------------------------------------
    // Pattern timing
    // ------------------------------------------------------------
    always_comb begin
        case (cfg_in.csel)
            CS_INT: tick = 1'b1;
            CS_FRONT: tick = front_clk_in && !s.front_q;
            CS_BP: tick = bp_clk_in && !s.bp_q;
            default: tick = 1'b0;
        endcase
    end
    // Short periods are stretched rather than refused
    assign period = (cfg_in.period < PW'(MIN_PERIOD)) ? PW'(MIN_PERIOD) : cfg_in.period;
    assign running = (s.st == ST_SETTLE) || (s.st == ST_MEAS);
    // Source mode holds the first sample until the prefetch has landed a word;
    // otherwise the opening stimulus event would always find the FIFO empty
    assign stall = cfg_in.src && !f_out_valid && (s.phase == '0) && (s.sample == '0)
        && (s.loop == '0);
    assign pace = tick && !stall;
    assign last_phase = running && pace && (s.phase == period - 1'b1);
    assign stim_evt = running && pace && (s.phase == '0);
    assign capt_evt = running && pace && (s.phase == cfg_in.capt_phase);
    assign start_ok = start_in && !config_in && ((s.st == ST_IDLE) || (s.st == ST_DONE));
    assign drained = (s.beat == '0) && !f_out_valid && !s.rd_pend && !s.fetch_act;

    // Memory ports: capture writes win over host writes
    assign cap_we = f_out_valid && !cfg_in.src;
    assign mem_we = cap_we || (host_in.wr && !running && s.st != ST_DRAIN);
    assign waddr = cap_we ? s.cap_addr : host_in.addr;
    assign wdata = cap_we ? f_out_data : host_in.wdata;
    assign raddr = (s.fetch_act && f_in_ready && !s.rd_pend) ?
        AW'(cfg_in.base + s.fetch_idx) : host_in.addr;
    assign f_out_ready = cfg_in.src ? (stim_evt || s.st == ST_DRAIN) : 1'b1;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [BW-1:0] take;
        logic [DW-1:0] sh;
        logic [DW-1:0] word;
        take = '0;
        sh = s.shreg;
        word = '0;
        next_s = s;
        f_in_valid = 1'b0;
        f_in_data = '0;
        next_s.front_q = front_clk_in;
        next_s.bp_q = bp_clk_in;
        // Phase counter runs only in the settle and measurement states
        if (!running) begin
            next_s.phase = '0;
        end else if (pace) begin
            next_s.phase = last_phase ? '0 : s.phase + 1'b1;
        end
        // Sample and loop counters
        if (last_phase) begin
            if (cfg_in.len == '0 || s.sample == cfg_in.len - 1'b1) begin
                next_s.sample = '0;
                if (s.st == ST_SETTLE) begin
                    if (s.loop == cfg_in.settle - 1'b1) begin
                        next_s.loop = '0;
                        next_s.st = ST_MEAS;
                    end else begin
                        next_s.loop = s.loop + 1'b1;
                    end
                end else if (cfg_in.meas == '0 || s.loop == cfg_in.meas - 1'b1) begin
                    next_s.st = ST_DRAIN;
                end else begin
                    next_s.loop = s.loop + 1'b1;
                end
            end else begin
                next_s.sample = s.sample + 1'b1;
            end
        end
        if (s.st == ST_DRAIN && drained) begin
            next_s.st = ST_DONE;
            next_s.ready = 1'b1;
        end
        // Stimulus prefetch, one read per two cycles so a push never meets a full FIFO
        f_in_valid = s.rd_pend;
        f_in_data = mem_q;
        next_s.rd_pend = 1'b0;
        if (cfg_in.src && s.fetch_act && f_in_ready && !s.rd_pend) begin
            next_s.rd_pend = 1'b1;
            if (cfg_in.len == '0 || s.fetch_idx == cfg_in.len - 1'b1) begin
                next_s.fetch_idx = '0;
                next_s.fetch_loop = s.fetch_loop + 1'b1;
                if (s.fetch_loop == {1'b0, cfg_in.settle} + {1'b0, cfg_in.meas} - 1'b1) begin
                    next_s.fetch_act = 1'b0;
                end
            end else begin
                next_s.fetch_idx = s.fetch_idx + 1'b1;
            end
        end
        // Capture direction
        if (!cfg_in.src && tick && (capt_evt || s.beat != '0)) begin
            take = capt_evt ? beats_of(cfg_in.xfer) : s.beat;
            if (capt_evt) begin
                next_s.keep = (s.st == ST_MEAS);
            end
            case (cfg_in.xfer)
                XF_PAR: sh = dut_data_in;
                XF_BYTE: sh = {s.shreg[DW-9:0], dut_data_in[7:0]};
                XF_SER: sh = {s.shreg[DW-2:0], dut_serial_in};
                default: sh = dut_data_in;
            endcase
            next_s.shreg = sh;
            next_s.beat = take - 1'b1;
            if (take == BW'(1) && (capt_evt ? (s.st == ST_MEAS) : s.keep)) begin
                f_in_valid = 1'b1;
                f_in_data = cfg_in.msb_inv ? (sh ^ MSB_BIT) : sh;
                if (!f_in_ready) begin
                    next_s.overrun = 1'b1;
                end
            end
        end
        // Source direction
        if (cfg_in.src && stim_evt) begin
            if (f_out_valid) begin
                word = cfg_in.msb_inv ? (f_out_data ^ MSB_BIT) : f_out_data;
                word = word & cfg_in.mask;
                next_s.beat = beats_of(cfg_in.xfer) - 1'b1;
                case (cfg_in.xfer)
                    XF_BYTE: begin
                        next_s.dout = {{(DW-8){1'b0}}, word[DW-1 -: 8]};
                        next_s.shreg = {word[DW-9:0], 8'h00};
                    end
                    XF_SER: begin
                        next_s.sout = word[DW-1];
                        next_s.shreg = {word[DW-2:0], 1'b0};
                    end
                    default: begin
                        next_s.dout = word;
                    end
                endcase
            end else begin
                next_s.underrun = 1'b1;
            end
        end else if (cfg_in.src && tick && s.beat != '0) begin
            next_s.beat = s.beat - 1'b1;
            if (cfg_in.xfer == XF_SER) begin
                next_s.sout = s.shreg[DW-1];
                next_s.shreg = {s.shreg[DW-2:0], 1'b0};
            end else begin
                next_s.dout = {{(DW-8){1'b0}}, s.shreg[DW-1 -: 8]};
                next_s.shreg = {s.shreg[DW-9:0], 8'h00};
            end
        end
        if (s.st == ST_DRAIN && !cfg_in.src) begin
            next_s.beat = s.beat;
        end
        next_s.doe = cfg_in.src;
        // Pattern outputs, registered
        next_s.user = running ? hit : '0;
        // Rises on the stimulus event itself, so its edge and the new word coincide
        next_s.ded[D_STIM] = running && (stim_evt
            || (s.phase != '0 && s.phase < (period >> 1)));
        next_s.ded[D_CAPT] = running && (next_s.phase == cfg_in.capt_phase);
        next_s.ded[D_BYTE] = (cfg_in.xfer == XF_BYTE) && tick && (capt_evt || stim_evt
            || s.beat != '0);
        next_s.ded[D_SER] = (cfg_in.xfer == XF_SER) && tick && (capt_evt || stim_evt
            || s.beat != '0);
        next_s.ded[D_LOAD] = stim_evt && cfg_in.src;
        next_s.ded[D_STORE] = cap_we;
        next_s.ded[D_WIN] = (next_s.st == ST_MEAS);
        // Capture storage, consecutive across loops
        if (cap_we) begin
            next_s.cap_addr = s.cap_addr + 1'b1;
        end
        // Start and return to configuration
        if (config_in) begin
            next_s.st = ST_IDLE;
            next_s.ready = 1'b0;
            next_s.fetch_act = 1'b0;
        end else if (start_ok) begin
            next_s.st = (cfg_in.settle == '0) ? ST_MEAS : ST_SETTLE;
            next_s.ready = 1'b0;
            next_s.sample = '0;
            next_s.loop = '0;
            next_s.beat = '0;
            next_s.cap_addr = '0;
            next_s.fetch_act = cfg_in.src;
            next_s.fetch_idx = '0;
            next_s.fetch_loop = '0;
            next_s.underrun = 1'b0;
            next_s.overrun = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Shared capture/stimulus memory, one write and one read port
    always_ff @(posedge sys_clk_in) begin
        if (mem_we) begin
            mem[waddr] <= wdata;
        end
        mem_q <= mem[raddr];
    end

    assign rd_data_out = mem_q;
    assign dut_data_out = s.dout;
    assign dut_data_oe_out = s.doe;
    assign dut_serial_out = s.sout;
    assign user_out = s.user;
    assign ded_out = s.ded;
    assign ready_out = s.ready;
    assign underrun_out = s.underrun;
    assign overrun_out = s.overrun;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [7:0] gap;
    logic seen;
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || start_ok) begin
            gap <= '0;
            seen <= 1'b0;
        end else if (stim_evt) begin
            gap <= '0;
            seen <= 1'b1;
        end else if (gap != 8'hFF) begin
            gap <= gap + 1'b1;
        end
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    sequence settle_end_s;
        s.st == ST_SETTLE && last_phase ##1 s.st == ST_MEAS;
    endsequence
    sequence finish_s;
        s.st == ST_DRAIN && drained && !config_in && !start_in;
    endsequence

    loop_switch_a: assert property (settle_end_s |-> s.loop == '0 && s.sample == '0)
        else $error("measurement loops did not start from zero");
    ready_set_a: assert property (finish_s |=> ready_out && s.st == ST_DONE)
        else $error("ready not raised at end of measurement");
    ready_hold_a: assert property (ready_out && !config_in && !start_in |=> ready_out)
        else $error("ready dropped without start or config");
    ready_clear_a: assert property (start_ok |=> !ready_out ##1 !ready_out)
        else $error("ready not cleared by start");
    user_win_a: assert property (running && hit[0] |=> user_out[0])
        else $error("user channel missed its window");
    cap_msb_a: assert property (f_in_valid && !cfg_in.src && cfg_in.msb_inv
        |-> f_in_data[DW-1] != next_s.shreg[DW-1])
        else $error("captured msb not inverted");
    mask_out_a: assert property (cfg_in.src && stim_evt && f_out_valid && cfg_in.xfer == XF_PAR
        && $stable(cfg_in.mask) |=> (dut_data_out & ~cfg_in.mask) == '0)
        else $error("masked bit driven");
    store_step_a: assert property (cap_we && !start_ok && !config_in
        |=> s.cap_addr == $past(s.cap_addr) + 1'b1 && ded_out[D_STORE])
        else $error("capture address did not advance");
    rate_min_a: assert property (stim_evt && seen |-> gap >= 8'(MIN_PERIOD - 1))
        else $error("sample rate above limit");
    stim_clk_a: assert property (stim_evt |=> ded_out[D_STIM] ##1 ded_out[D_LOAD] == 1'b0
        || !cfg_in.src)
        else $error("stimulus clock not high after sample advance");
endmodule

//--- test/ctdp_conv_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Converter under test
// ----------------------------------------------------------------
module ctdp_conv_model import ctdp_pkg::*; (
    // Clock
    input wire logic clk_in,
    // Pattern and data from the module
    input wire logic stim_clk_in,
    input wire logic [DW-1:0] code_in,
    input wire logic code_oe_in,
    // Converted result
    output logic [DW-1:0] result_out,
    output logic result_bit_out
);
    logic stim_q;
    logic [DW-1:0] conv_cnt;
    logic [DW-1:0] got [$];

    // Before the first conversion the result is junk, not a usable code
    initial begin
        stim_q = 1'b0;
        conv_cnt = 16'h0000;
        result_out = 16'hEDCF;
    end

    assign result_bit_out = result_out[DW-1];

    // Each rising stimulus clock edge converts one sample; the result is held a full period
    always @(posedge clk_in) begin
        stim_q <= stim_clk_in;
        if (stim_clk_in && !stim_q) begin
            result_out <= 16'h1230 + conv_cnt;
            conv_cnt <= conv_cnt + 16'h0001;
            if (code_oe_in) begin
                got.push_back(code_in);
            end
        end
    end
endmodule

//--- test/ctdp_top_tb.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module ctdp_top_tb import ctdp_pkg::*;;
    logic sys_clk_in;
    logic rst_in;
    ctdp_cfg_t cfg;
    logic [N_USER-1:0][PW-1:0] u_on;
    logic [N_USER-1:0][PW-1:0] u_off;
    logic start;
    logic cfg_ret;
    ctdp_host_t host;
    logic [DW-1:0] rd_data;
    logic [DW-1:0] din;
    logic sin;
    logic [DW-1:0] dout;
    logic doe;
    logic sout;
    logic [N_USER-1:0] user;
    logic [N_DED-1:0] ded;
    logic ready;
    logic under;
    logic over;
    logic [DW-1:0] d;
    logic [DW-1:0] exp_w [2];
    int bad_count = 0;
    int samples_checked = 0;
    int gap = 0;
    int since = 0;
    int user_hi = 0;
    int capt_hi = 0;
    logic stim_q = 1'b0;

    ctdp_top u_ctdp_top (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cfg_in(cfg),
        .user_on_in(u_on), .user_off_in(u_off), .start_in(start), .config_in(cfg_ret),
        .front_clk_in(1'b0), .bp_clk_in(1'b0), .host_in(host), .rd_data_out(rd_data),
        .dut_data_in(din), .dut_serial_in(sin), .dut_data_out(dout),
        .dut_data_oe_out(doe), .dut_serial_out(sout), .user_out(user), .ded_out(ded),
        .ready_out(ready), .underrun_out(under), .overrun_out(over));

    ctdp_conv_model u_ctdp_conv_model (.clk_in(sys_clk_in), .stim_clk_in(ded[D_STIM]),
        .code_in(dout), .code_oe_in(doe), .result_out(din), .result_bit_out(sin));

    // 20 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    // Spacing of stimulus clock rising edges; pattern pulses counted in capture mode
    always @(posedge sys_clk_in) begin
        stim_q <= ded[D_STIM];
        since <= since + 1;
        if (ded[D_STIM] && !stim_q) begin
            gap <= since;
            since <= 1;
        end
        if (!doe) begin
            user_hi <= user_hi + int'(user[0]);
            capt_hi <= capt_hi + int'(ded[D_CAPT]);
        end
    end

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic host_wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
        host <= '{1'b1, a, v};
        @(negedge sys_clk_in);
        host.wr <= 1'b0;
        @(negedge sys_clk_in);
    endtask

    // Read port is registered: data appears one cycle after the address
    task automatic host_rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
        host.addr <= a;
        @(negedge sys_clk_in);
        v = rd_data;
    endtask

    // Start a run and wait, bounded, for completion
    task automatic run();
        start <= 1'b1;
        @(negedge sys_clk_in);
        start <= 1'b0;
        check({15'h0000, ready}, 16'h0000);
        for (int i = 0; i < 2000 && ready !== 1'b1; i++) @(negedge sys_clk_in);
        check({15'h0000, ready}, 16'h0001);
    endtask

    task automatic close_out();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the runs need
    initial begin
        repeat (8000) @(posedge sys_clk_in);
        bad_count++;
        close_out();
    end

    initial begin
        rst_in = 1'b1;
        start = 1'b0;
        cfg_ret = 1'b0;
        host = '0;
        u_on = '0;
        u_off = '0;
        u_off[0] = 12'h003;
        cfg = '{1'b0, XF_PAR, 1'b1, 16'hFFFF, 16'h0001, 16'h0002, 10'h000, 10'h004,
            12'h004, 12'h005, CS_INT};
        repeat (16) @(negedge sys_clk_in);
        rst_in = 1'b0;
        // Capture: 1 settle + 2 measurement loops of 4 samples, period asked 4
        run();
        check(16'(gap), 16'(MIN_PERIOD));
        check(16'(user_hi), 16'h0024);
        check(16'(capt_hi), 16'h000C);
        check({15'h0000, over}, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            host_rd(10'(i), d);
            check(d, (16'h1234 + 16'(i)) ^ MSB_BIT);
        end
        cfg_ret <= 1'b1;
        @(negedge sys_clk_in);
        cfg_ret <= 1'b0;
        @(negedge sys_clk_in);
        check({15'h0000, ready}, 16'h0000);
        // Source: two-word stimulus at base 4 replayed over 2 loops, inverted and masked
        host_wr(10'h004, 16'h0123);
        host_wr(10'h005, 16'h8F0F);
        exp_w[0] = 16'h8120;
        exp_w[1] = 16'h0F00;
        cfg = '{1'b1, XF_PAR, 1'b1, 16'h8FF0, 16'h0000, 16'h0002, 10'h004, 10'h002,
            12'h00A, 12'h005, CS_INT};
        @(negedge sys_clk_in);
        run();
        check({15'h0000, doe}, 16'h0001);
        check({15'h0000, under}, 16'h0000);
        check(16'(u_ctdp_conv_model.got.size()), 16'h0004);
        for (int k = 0; k < 4 && k < u_ctdp_conv_model.got.size(); k++) begin
            check(u_ctdp_conv_model.got[k], exp_w[k % 2]);
        end
        // Same stimulus byte-wise: the model latches the high byte on each stimulus edge
        cfg.xfer = XF_BYTE;
        @(negedge sys_clk_in);
        run();
        check(16'(u_ctdp_conv_model.got.size()), 16'h0008);
        for (int k = 4; k < 8 && k < u_ctdp_conv_model.got.size(); k++) begin
            check(u_ctdp_conv_model.got[k], {8'h00, exp_w[k % 2][15:8]});
        end
        close_out();
    end
endmodule
